// >>> rtl/npx_decoder_cfg.svh
// Register offsets, field positions and reset values of the escape decoder.
// Assumes inclusion by bare name; definitions only.
`ifndef NPX_DECODER_CFG_SVH
`define NPX_DECODER_CFG_SVH

// Instruction word layout: first byte in bits 15:8, second byte in 7:0
`define COPRO_TAG_VAL      5'h1b
`define COPRO_TAG_HI       15
`define COPRO_TAG_LO       11
`define REG_FORM_KIND      2'h3

// Register byte offsets
`define OFS_CTRL           8'h00
`define OFS_STATUS         8'h04
`define OFS_DECODE         8'h08
`define OFS_OFFSET         8'h0c
`define OFS_COUNTS         8'h10

// CTRL fields
`define CTRL_ENABLE_BIT    0
`define CTRL_CLR_CNT_BIT   1
`define CTRL_RESET_VAL     2'h1

// STATUS fields
`define STAT_BUSY_BIT      0
`define STAT_VALID_BIT     1
`define STAT_REJECT_BIT    2
`define STAT_CKM_BIT       3
`define STAT_SHORT_BIT     4

`endif

// >>> rtl/npx_decoder_pkg.sv
// Types shared by the escape decoder and its helpers.
// Assumes nothing of its surroundings.
package npx_decoder_pkg;

    // Memory operand type selected by the operand_format field
    typedef enum logic [1:0]
    {
        FMT_REAL32  = 2'h0,
        FMT_INT32   = 2'h1,
        FMT_REAL64  = 2'h2,
        FMT_INT16   = 2'h3
    } operand_format_t;

    // One decoded instruction, 26 bits
    typedef struct packed
    {
        logic            tag_ok;
        logic            reg_form;
        operand_format_t operand_format;
        logic            target_slot;
        logic            reversed;
        logic            source_first;
        logic            pop_after;
        logic [2:0]      opcode_upper;
        logic [2:0]      opcode_lower;
        logic [2:0]      stack_slot;
        logic [1:0]      addressing_kind;
        logic [2:0]      reg_mem;
        logic [1:0]      offset_len;
        logic            base_index;
        logic            sub_div;
    } decoded_t;

endpackage

// >>> rtl/strobe_sync.sv
// Two-flop synchroniser for one asynchronous active-low strobe, with a
// falling-edge pulse taken from the settled stage only.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module strobe_sync
(
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_strobe_n,
    output logic      o_active,
    output logic      o_start
);
    logic meta_n;
    logic stable_n;
    logic prev_n;

    // First stage feeds only the second; idle level is high
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_n   <= 1'b1;
            stable_n <= 1'b1;
            prev_n   <= 1'b1;
        end
        else
        begin
            meta_n   <= i_strobe_n;
            stable_n <= meta_n;
            prev_n   <= stable_n;
        end
    end

    assign o_active = ~stable_n;
    assign o_start  = prev_n & ~stable_n;
endmodule

// >>> rtl/address_mode_decode.sv
// Host-style addressing decode: offset length and base-plus-index use,
// from the addressing_kind and register/memory fields (16-bit addressing).
// Assumes it is purely combinational.
`timescale 1ns/100ps
module address_mode_decode
(
    input  wire logic [1:0] i_addressing_kind,
    input  wire logic [2:0] i_reg_mem,
    output logic [1:0]      o_offset_len,
    output logic            o_base_index
);
    // Kind 00 with r/m 110 is direct address with a two-byte offset
    always_comb
    begin
        case (i_addressing_kind)
            2'h0:    o_offset_len = (i_reg_mem == 3'h6) ? 2'h2 : 2'h0;
            2'h1:    o_offset_len = 2'h1;
            2'h2:    o_offset_len = 2'h2;
            default: o_offset_len = 2'h0;
        endcase
    end

    // r/m 000..011 name a base and an index register
    assign o_base_index = (i_addressing_kind != 2'h3) && !i_reg_mem[2];
endmodule

// >>> rtl/escape_instruction_decoder.sv
// Escape-class instruction decoder of the numeric coprocessor.
// Assumes i_clk at 250 MHz; host strobes and reset arrive asynchronously;
// host data is stable while its strobe is active.
`timescale 1ns/100ps
`include "npx_decoder_cfg.svh"
module escape_instruction_decoder
    import npx_decoder_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W  = 16
)
(
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    input  wire logic              i_clock_mode_select,
    input  wire logic              i_coprocessor_write_strobe_n,
    input  wire logic              i_coprocessor_read_strobe_n,
    input  wire logic [15:0]       i_host_data,
    input  wire logic              i_host_two_bytes,
    output logic [15:0]            o_host_data,
    output logic                   o_host_data_oe,
    output decoded_t               o_decoded,
    output logic [15:0]            o_offset,
    output logic                   o_decode_valid,
    output logic                   o_reject,
    output logic                   o_busy,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [31:0]            o_rdata
);
    // Refuse shapes the register map and counters cannot serve
    // Checked at elaboration, so a bad instance never reaches a run
    if (ADDR_W < 5 || CNT_W < 1 || CNT_W > 16)
    begin : g_bad_shape
        $error("escape_instruction_decoder: unsupported ADDR_W or CNT_W");
    end

    typedef enum logic [0:0]
    {
        ST_OPCODE,
        ST_OFFSET
    } phase_t;

    phase_t     phase;
    phase_t     next_phase;
    logic       rst_meta_n;
    logic       rst_n;
    logic       wr_active;
    logic       wr_start;
    logic       rd_active;
    logic       rd_start;
    logic [1:0] ctrl;
    logic       valid_seen;
    logic       reject_seen;
    logic       short_seen;
    logic [CNT_W-1:0] accept_cnt;
    logic [CNT_W-1:0] reject_cnt;
    logic [1:0] pend_len;
    decoded_t   next_decoded;
    logic [1:0] word_offset_len;
    logic       word_base_index;
    logic       tag_hit;
    logic       take_opcode;
    logic       take_offset;
    logic       bad_word;
    logic       clr_cnt;

    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Host strobes are sampled through two flops each
    strobe_sync u_wr_sync
    (
        .i_clk      (i_clk),
        .i_arst_n   (rst_n),
        .i_strobe_n (i_coprocessor_write_strobe_n),
        .o_active   (wr_active),
        .o_start    (wr_start)
    );

    strobe_sync u_rd_sync
    (
        .i_clk      (i_clk),
        .i_arst_n   (rst_n),
        .i_strobe_n (i_coprocessor_read_strobe_n),
        .o_active   (rd_active),
        .o_start    (rd_start)
    );

    // Offset presence and base-plus-index come from the second byte
    address_mode_decode u_mode
    (
        .i_addressing_kind (i_host_data[7:6]),
        .i_reg_mem         (i_host_data[2:0]),
        .o_offset_len      (word_offset_len),
        .o_base_index      (word_base_index)
    );

    assign tag_hit     = i_host_data[`COPRO_TAG_HI:`COPRO_TAG_LO] == `COPRO_TAG_VAL;
    assign take_opcode = wr_start && (phase == ST_OPCODE) && ctrl[`CTRL_ENABLE_BIT];
    assign take_offset = wr_start && (phase == ST_OFFSET);
    assign bad_word    = !tag_hit || !i_host_two_bytes;
    assign clr_cnt     = i_wr && (i_addr == ADDR_W'(`OFS_CTRL)) && i_wdata[`CTRL_CLR_CNT_BIT];

    // Field extraction of an opcode word
    always_comb
    begin
        next_decoded                 = '0;
        next_decoded.tag_ok          = tag_hit;
        next_decoded.reg_form        = i_host_data[7:6] == `REG_FORM_KIND;
        next_decoded.opcode_upper    = i_host_data[10:8];
        next_decoded.addressing_kind = i_host_data[7:6];
        next_decoded.reg_mem         = i_host_data[2:0];
        next_decoded.stack_slot      = i_host_data[2:0];
        next_decoded.opcode_lower    = i_host_data[5:3];
        // Arithmetic group has bit 8 clear; lower codes 1xx are subtract/divide
        next_decoded.sub_div         = !i_host_data[8] && i_host_data[5];
        if (next_decoded.sub_div)
        begin
            next_decoded.reversed     = i_host_data[3];
            next_decoded.opcode_lower = {i_host_data[5:4], 1'b0};
        end
        if (next_decoded.reg_form)
        begin
            next_decoded.target_slot  = i_host_data[10];
            next_decoded.pop_after    = i_host_data[9];
            next_decoded.offset_len   = 2'h0;
            next_decoded.base_index   = 1'b0;
        end
        else
        begin
            next_decoded.operand_format = operand_format_t'(i_host_data[10:9]);
            next_decoded.opcode_upper   = {2'h0, i_host_data[8]};
            next_decoded.offset_len     = word_offset_len;
            next_decoded.base_index     = word_base_index;
        end
        // Memory forms keep the stack top as destination
        next_decoded.source_first = next_decoded.reversed ^ next_decoded.target_slot;
    end

    // Phase: wait for the offset word when the addressing fields ask for one
    always_comb
    begin
        next_phase = phase;
        case (phase)
            ST_OPCODE:
            begin
                if (take_opcode && !bad_word && next_decoded.offset_len != 2'h0)
                    next_phase = ST_OFFSET;
            end
            ST_OFFSET:
            begin
                if (take_offset)
                    next_phase = ST_OPCODE;
            end
            default: next_phase = ST_OPCODE;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase <= ST_OPCODE;
        else
            phase <= next_phase;
    end

    // Decoded fields are held until the next accepted opcode
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_decoded <= '0;
            pend_len  <= 2'h0;
        end
        else if (take_opcode && !bad_word)
        begin
            o_decoded <= next_decoded;
            pend_len  <= next_decoded.offset_len;
        end
    end

    // Offset word: one byte is sign-extended, two bytes taken whole
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_offset <= 16'h0000;
        else if (take_opcode && !bad_word)
            o_offset <= 16'h0000;
        else if (take_offset)
            o_offset <= (pend_len == 2'h1) ? {{8{i_host_data[7]}}, i_host_data[7:0]}
                                           : i_host_data;
    end

    // Completion and refusal pulses, one cycle each
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_decode_valid <= 1'b0;
            o_reject       <= 1'b0;
        end
        else
        begin
            o_decode_valid <= (take_opcode && !bad_word && next_decoded.offset_len == 2'h0)
                              || take_offset;
            o_reject       <= take_opcode && bad_word;
        end
    end

    // Busy from the first strobe edge of an instruction until the write strobe of its last word is released
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_busy <= 1'b0;
        else
            o_busy <= (next_phase == ST_OFFSET) || (wr_active && ctrl[`CTRL_ENABLE_BIT]);
    end

    // Host read returns the low half of the decoded word while its strobe stands
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_host_data    <= 16'h0000;
            o_host_data_oe <= 1'b0;
        end
        else
        begin
            if (rd_start)
                o_host_data <= o_decoded[15:0];
            o_host_data_oe <= rd_active;
        end
    end

    // Control register; the counter clear bit is a command, not stored
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl <= `CTRL_RESET_VAL;
        else if (i_wr && i_addr == ADDR_W'(`OFS_CTRL))
            ctrl <= {1'b0, i_wdata[`CTRL_ENABLE_BIT]};
    end

    // Sticky flags: a new event in the clearing cycle wins over the clear
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_seen  <= 1'b0;
            reject_seen <= 1'b0;
            short_seen  <= 1'b0;
        end
        else
        begin
            if (o_decode_valid)
                valid_seen <= 1'b1;
            else if (i_wr && i_addr == ADDR_W'(`OFS_STATUS) && i_wdata[`STAT_VALID_BIT])
                valid_seen <= 1'b0;
            if (o_reject)
                reject_seen <= 1'b1;
            else if (i_wr && i_addr == ADDR_W'(`OFS_STATUS) && i_wdata[`STAT_REJECT_BIT])
                reject_seen <= 1'b0;
            if (take_opcode && tag_hit && !i_host_two_bytes)
                short_seen <= 1'b1;
            else if (i_wr && i_addr == ADDR_W'(`OFS_STATUS) && i_wdata[`STAT_SHORT_BIT])
                short_seen <= 1'b0;
        end
    end

    // Instruction counters saturate rather than wrap, so a long run stays readable
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            accept_cnt <= '0;
            reject_cnt <= '0;
        end
        else
        begin
            if (o_decode_valid && !(&accept_cnt))
                accept_cnt <= accept_cnt + 1'b1;
            else if (clr_cnt)
                accept_cnt <= '0;
            if (o_reject && !(&reject_cnt))
                reject_cnt <= reject_cnt + 1'b1;
            else if (clr_cnt)
                reject_cnt <= '0;
        end
    end

    // Read data stands in the cycle after the read strobe only
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_rdata <= 32'h0000_0000;
        else if (!i_rd)
            o_rdata <= 32'h0000_0000;
        else
        begin
            case (i_addr)
                ADDR_W'(`OFS_CTRL):   o_rdata <= {31'h0, ctrl[`CTRL_ENABLE_BIT]};
                ADDR_W'(`OFS_STATUS): o_rdata <= {27'h0, short_seen, i_clock_mode_select,
                                                  reject_seen, valid_seen, o_busy};
                ADDR_W'(`OFS_DECODE): o_rdata <= {6'h0, o_decoded};
                ADDR_W'(`OFS_OFFSET): o_rdata <= {16'h0, o_offset};
                ADDR_W'(`OFS_COUNTS): o_rdata <= {16'(reject_cnt), 16'(accept_cnt)};
                default:              o_rdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> verif/escape_decoder_chk.sv
// Checker: concurrent properties on the escape decoder ports.
// Assumes one clock and the active-low asynchronous reset of the top.
`timescale 1ns/100ps
module escape_decoder_chk
    import npx_decoder_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_arst_n,
    input  wire logic     i_coprocessor_write_strobe_n,
    input  wire logic     o_decode_valid,
    input  wire logic     o_reject,
    input  wire decoded_t o_decoded
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Short aliases keep each property on one line
    logic     v;
    logic     w;
    decoded_t d;
    assign v = o_decode_valid;
    assign w = i_coprocessor_write_strobe_n;
    assign d = o_decoded;

    // Offset size of 16-bit host addressing
    function automatic logic [1:0] olen(input logic [1:0] k, input logic [2:0] rm);
        return (k == 2'h1) ? 2'h1 : (k == 2'h2 || (k == 2'h0 && rm == 3'h6)) ? 2'h2 : 2'h0;
    endfunction

    property p_tag; v |-> d.tag_ok; endproperty
    a_tag: assert property (p_tag) else $error("valid without prefix tag");
    property p_excl; not (v && o_reject); endproperty
    a_excl: assert property (p_excl) else $error("valid and reject together");
    property p_form; v |-> d.reg_form == (d.addressing_kind == 2'h3); endproperty
    a_form: assert property (p_form) else $error("form class wrong");
    property p_order; v |-> d.source_first == (d.reversed ^ d.target_slot); endproperty
    a_order: assert property (p_order) else $error("operand order wrong");
    property p_regoff; v && d.reg_form |-> d.offset_len == 2'h0 && !d.base_index; endproperty
    a_regoff: assert property (p_regoff) else $error("register form with offset");
    property p_olen; v && !d.reg_form |-> d.offset_len == olen(d.addressing_kind, d.reg_mem); endproperty
    a_olen: assert property (p_olen) else $error("offset length wrong");
    property p_bi; v && !d.reg_form |-> d.base_index == (d.reg_mem < 3'h4); endproperty
    a_bi: assert property (p_bi) else $error("base index flag wrong");
    property p_rev; v && d.reversed |-> d.sub_div && !d.opcode_lower[0]; endproperty
    a_rev: assert property (p_rev) else $error("reverse bit outside sub/div");
    property p_sync; v || o_reject |-> !$past(w, 2) || !$past(w, 3) || !$past(w, 4); endproperty
    a_sync: assert property (p_sync) else $error("pulse without write strobe");
endmodule

bind escape_instruction_decoder escape_decoder_chk escape_decoder_chk_i
(
    .i_clk, .i_arst_n, .i_coprocessor_write_strobe_n, .o_decode_valid, .o_reject, .o_decoded
);

// >>> verif/host_cpu_model.sv
// Host CPU model: passes escape words and reads over the coprocessor strobes.
// Assumes the bench calls its tasks; strobes change just after a clock edge.
`timescale 1ns/100ps
module host_cpu_model
(
    input  wire logic        i_clk,
    input  wire logic [15:0] i_dev_data,
    input  wire logic        i_dev_oe,
    output logic             o_wr_n,
    output logic             o_rd_n,
    output logic [15:0]      o_data,
    output logic             o_two_bytes
);
    // Idle bus at time zero
    initial
    begin
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_data = 16'h5a5a;
        o_two_bytes = 1'b1;
    end

    // Word held over the whole low phase; the gap keeps strobes apart
    task automatic put(input logic [15:0] w, input logic two);
        @(posedge i_clk);
        o_data <= w;
        o_two_bytes <= two;
        o_wr_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_wr_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_data <= ~w; // No stale word after release
    endtask

    // Read: sampled late in the low phase, after the sync delay
    task automatic get(output logic [15:0] d, output logic oe);
        @(posedge i_clk);
        o_rd_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        #1 d = i_dev_data;
        oe = i_dev_oe;
        @(posedge i_clk);
        o_rd_n <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// >>> verif/test_escape_instruction_decoder.sv
// Bench: drives the decoder through a host model and the register port.
// Assumes the checker bind and the host model are compiled with it.
`timescale 1ns/100ps
`include "npx_decoder_cfg.svh"
module test_escape_instruction_decoder;
    import npx_decoder_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        i_clock_mode_select = 1'b1;
    logic        wr_n;
    logic        rd_n;
    logic        i_host_two_bytes;
    logic [15:0] i_host_data;
    logic [15:0] o_host_data;
    logic [15:0] o_offset;
    logic        o_host_data_oe;
    logic        o_decode_valid;
    logic        o_reject;
    logic        o_busy;
    decoded_t    o_decoded;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] o_rdata;
    logic [31:0] rd;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    int          num_errors = 0;
    int          n_compared = 0;
    int          n_pulse = 0;
    int          n_rej = 0;

    escape_instruction_decoder escape_instruction_decoder_i
    (
        .i_clk, .i_arst_n, .i_clock_mode_select, .i_coprocessor_write_strobe_n(wr_n),
        .i_coprocessor_read_strobe_n(rd_n), .i_host_data, .i_host_two_bytes, .o_host_data,
        .o_host_data_oe, .o_decoded, .o_offset, .o_decode_valid, .o_reject, .o_busy,
        .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata
    );
    host_cpu_model host_cpu_model_i
    (
        .i_clk, .i_dev_data(o_host_data), .i_dev_oe(o_host_data_oe), .o_wr_n(wr_n),
        .o_rd_n(rd_n), .o_data(i_host_data), .o_two_bytes(i_host_two_bytes)
    );

    // Clock of 4 ns
    initial
    begin
        forever #2 i_clk = ~i_clk;
    end

    // Pulse counts let scenarios judge outcomes after the edge has settled
    always @(posedge i_clk)
    begin
        if (o_decode_valid === 1'b1)
            n_pulse <= n_pulse + 1;
        if (o_reject === 1'b1)
            n_rej <= n_rej + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d, compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Register port: one-cycle strobes, read data in the following cycle
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd = o_rdata;
    endtask

    // Expected decode of a word, field for field
    function automatic logic [31:0] dec(input logic [15:0] w);
        decoded_t e;
        logic     rf;
        e = '0;
        rf = w[7:6] == 2'h3;
        e.tag_ok = w[15:11] == 5'h1b;
        e.reg_form = rf;
        e.opcode_upper = rf ? w[10:8] : {2'h0, w[8]};
        e.operand_format = rf ? FMT_REAL32 : operand_format_t'(w[10:9]);
        e.target_slot = rf & w[10];
        e.pop_after = rf & w[9];
        e.sub_div = !w[8] & w[5];
        e.reversed = e.sub_div & w[3];
        e.source_first = e.reversed ^ e.target_slot;
        e.opcode_lower = {w[5:4], w[3] & !e.reversed};
        e.stack_slot = w[2:0];
        e.addressing_kind = w[7:6];
        e.reg_mem = w[2:0];
        if (!rf)
        begin
            e.offset_len = w[7:6] == 2'h1 ? 2'h1 : (w[7] || w[2:0] == 3'h6) ? 2'h2 : 2'h0;
            e.base_index = w[2:0] < 3'h4;
        end
        return {6'h0, e};
    endfunction

    task automatic chk_dec(input logic [15:0] w);
        rreg(`OFS_DECODE);
        check(rd, dec(w), "decode");
    endtask

    // One host write, then the valid and reject pulse counts it caused
    task automatic send(input logic [15:0] w, input logic b2, input int v, input int r);
        int v0;
        int r0;
        v0 = n_pulse;
        r0 = n_rej;
        host_cpu_model_i.put(w, b2);
        check(n_pulse - v0, v, "valid pulses");
        check(n_rej - r0, r, "reject pulses");
    endtask

    task automatic t_reset();
        check(o_decode_valid | o_reject | o_host_data_oe, 0, "idle");
        rreg(`OFS_CTRL);
        check(rd, 32'h1, "ctrl");
        rreg(`OFS_STATUS);
        check(rd, 32'h8, "status");
        @(posedge i_clk);
        i_clock_mode_select <= 1'b0;
        rreg(`OFS_STATUS);
        check(rd, 32'h0, "mode pin low");
        @(posedge i_clk);
        i_clock_mode_select <= 1'b1;
        rreg(8'h14);
        check(rd, 32'h0, "unmapped");
    endtask

    // Reversed, popped, top and eighth slot register forms
    task automatic t_reg_forms();
        logic [15:0] t [5] = '{16'hdce9, 16'hdef8, 16'hd8e7, 16'hd8ef, 16'hd9c1};
        foreach (t[k])
        begin
            send(t[k], 1'b1, 1, 0);
            chk_dec(t[k]);
        end
    endtask

    // Every operand format, with and without base plus index
    task automatic t_mem_forms();
        logic [15:0] w;
        for (int m = 0; m < 4; m++)
        begin
            w = {5'h1b, m[1:0], 1'b0, 5'h02, m[0] ? 3'h0 : 3'h7};
            send(w, 1'b1, 1, 0);
            chk_dec(w);
        end
    endtask

    // Opcode waits for its offset word; one byte is sign-extended
    task automatic t_offsets();
        logic [15:0] op [4] = '{16'hd847, 16'hd887, 16'hd806, 16'hd840};
        logic [15:0] of [4] = '{16'h3c80, 16'h1234, 16'hbeef, 16'hc57f};
        logic [15:0] ex [4] = '{16'hff80, 16'h1234, 16'hbeef, 16'h007f};
        foreach (op[k])
        begin
            send(op[k], 1'b1, 0, 0);
            check(o_busy, 1'b1, "busy for offset");
            send(of[k], 1'b1, 1, 0);
            check(o_offset, ex[k], "offset");
            chk_dec(op[k]);
        end
    endtask

    // Wrong tag, single byte, then a good word; counters and sticky flags
    task automatic t_reject();
        wreg(`OFS_CTRL, 32'h3);
        wreg(`OFS_STATUS, 32'h16);
        send(16'hc8c1, 1'b1, 0, 1);
        send(16'hd9c1, 1'b0, 0, 1);
        send(16'hd9c1, 1'b1, 1, 0);
        rreg(`OFS_COUNTS);
        check(rd, 32'h00020001, "counts");
        rreg(`OFS_STATUS);
        check(rd, 32'h1e, "flags");
        wreg(`OFS_STATUS, 32'h16);
        rreg(`OFS_STATUS);
        check(rd, 32'h8, "flags cleared");
        wreg(`OFS_CTRL, 32'h0);
        send(16'hd9c1, 1'b1, 0, 0);
        wreg(`OFS_CTRL, 32'h1);
    endtask

    // Host read returns the low half of the decode while enabled
    task automatic t_read();
        logic [15:0] d;
        logic        oe;
        send(16'hdce9, 1'b1, 1, 0);
        host_cpu_model_i.get(d, oe);
        check(d, dec(16'hdce9) & 32'hffff, "host read");
        check(oe, 1'b1, "drive on read");
        check(o_host_data_oe, 1'b0, "released");
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_reset();
        t_reg_forms();
        t_mem_forms();
        t_offsets();
        t_reject();
        t_read();
        tally_and_finish();
    end

    // Hang guard
    initial
    begin
        #200000;
        num_errors++;
        tally_and_finish();
    end
endmodule
